// ### hdl/pwm_startup_ctrl.sv
`timescale 1ns/1ns
// Functional notes
// - Bootstrap variant starts only after supply rises past upper bootstrap threshold.
// - Under lockout: comparators, oscillator and gate drive all disabled.
// - Bootstrap variant re-enters lockout when supply falls below lower threshold.
// - Non-bootstrap leaves lockout when supply minimum and enable threshold both met.
// - Bootstrap variant also needs the bootstrap condition to leave lockout.
// - After enable falls, gate keeps switching for a fixed delay, then stops.
// - Flag pulled low while enable below threshold, released otherwise.
// - Flag depends only on the enable comparison, never on bootstrap lockout.
// - Soft-start begins only once every lockout condition has cleared.
// - Reference ramps zero to full over a fixed count of switching cycles.
// - Half-rate: oscillator divided by two, duty at most one half.
// - Quarter-rate: oscillator divided by four, duty at most three quarters.
// - Current-limit trip ends the present on-cycle within the propagation time.
// - Gate turns on at period start if pwm comparator low, off when high.
// - Bootstrap collapse forces a complete new startup including soft-start.
module pwm_startup_ctrl #(
   parameter bit                                     BOOTSTRAP             = 1'b1,
   parameter bit                                     QUARTER_RATE          = 1'b0,
   parameter logic [pwm_startup_pkg::SHUTDOWN_CNT_W-1:0] SHUTDOWN_DELAY_CYCLES =
      pwm_startup_pkg::SHUTDOWN_CNT_W'(pwm_startup_pkg::SHUTDOWN_DELAY_CYCLES)
) (
   input  wire logic                           ref_clk_in,
   input  wire logic                           reset_in,
   input  wire logic                           osc_tick_in,
   input  wire logic                           supply_above_min_in,
   input  wire logic                           supply_above_boot_high_in,
   input  wire logic                           supply_above_boot_low_in,
   input  wire logic                           enable_threshold_input_in,
   input  wire logic                           pwm_comparator_in,
   input  wire logic                           current_limit_comparator_in,
   output logic                                gate_drive_out,
   output logic                                undervoltage_flag_out,
   output logic                                undervoltage_flag_oe_out,
   output logic                                comparators_enable_out,
   output logic                                oscillator_enable_out,
   output logic                                lockout_out,
   output logic [pwm_startup_pkg::SS_W-1:0]    softstart_ref_out
);

   localparam int CURRENT_LIMIT_COMPARATOR_BOUND = pwm_startup_pkg::CURRENT_LIMIT_COMPARATOR_PROP_CYCLES;

   pwm_startup_pkg::ctrl_state_t state;
   pwm_startup_pkg::ctrl_state_t next_state;

   logic                                       boot_ok;
   logic                                       supply_ok;
   logic                                       ready;
   logic                                       active;
   logic                                       ss_done;
   logic                                       delay_done;
   logic [pwm_startup_pkg::SHUTDOWN_CNT_W-1:0] delay_count;
   logic [pwm_startup_pkg::SS_W-1:0]           ss_ref;
   logic                                       gate;
   logic                                       flag_oe;

   switch_timing_if timing ();

   switch_period_gen #(
      .QUARTER_RATE (QUARTER_RATE)
   ) u_period (
      .ref_clk_in  (ref_clk_in),
      .reset_in    (reset_in),
      .osc_tick_in (osc_tick_in),
      .timing      (timing.gen)
   );

   // Bootstrap hysteresis latch; the large gap lets the bias winding take over
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         boot_ok <= 1'b0;
      end else if (!BOOTSTRAP) begin
         boot_ok <= 1'b1;
      end else if (!supply_above_boot_low_in) begin
         boot_ok <= 1'b0;
      end else if (supply_above_boot_high_in) begin
         boot_ok <= 1'b1;
      end
   end

   // Supply and enable qualification
   assign supply_ok  = supply_above_min_in && boot_ok;
   assign ready      = supply_ok && enable_threshold_input_in;
   assign ss_done    = (ss_ref == pwm_startup_pkg::SS_FULL);
   assign delay_done = (delay_count >= SHUTDOWN_DELAY_CYCLES - 1'b1);
   assign active     = (state != pwm_startup_pkg::ST_LOCKOUT);

   // Next-state decision; supply loss always wins over the shutdown delay
   always_comb begin
      next_state = state;
      unique case (state)
         pwm_startup_pkg::ST_LOCKOUT: begin
            if (ready) begin
               next_state = pwm_startup_pkg::ST_SOFTSTART;
            end
         end
         pwm_startup_pkg::ST_SOFTSTART: begin
            if (!supply_ok) begin
               next_state = pwm_startup_pkg::ST_LOCKOUT;
            end else if (!enable_threshold_input_in) begin
               next_state = pwm_startup_pkg::ST_SHUTDOWN;
            end else if (ss_done) begin
               next_state = pwm_startup_pkg::ST_RUN;
            end
         end
         pwm_startup_pkg::ST_RUN: begin
            if (!supply_ok) begin
               next_state = pwm_startup_pkg::ST_LOCKOUT;
            end else if (!enable_threshold_input_in) begin
               next_state = pwm_startup_pkg::ST_SHUTDOWN;
            end
         end
         pwm_startup_pkg::ST_SHUTDOWN: begin
            if (!supply_ok) begin
               next_state = pwm_startup_pkg::ST_LOCKOUT;
            end else if (enable_threshold_input_in) begin
               next_state = ss_done ? pwm_startup_pkg::ST_RUN : pwm_startup_pkg::ST_SOFTSTART;
            end else if (delay_done) begin
               next_state = pwm_startup_pkg::ST_LOCKOUT;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         state <= pwm_startup_pkg::ST_LOCKOUT;
      end else begin
         state <= next_state;
      end
   end

   // Shutdown delay on the reference clock, which never stops during the delay
   always_ff @(posedge ref_clk_in) begin
      if (reset_in || state != pwm_startup_pkg::ST_SHUTDOWN) begin
         delay_count <= '0;
      end else begin
         delay_count <= delay_count + 1'b1;
      end
   end

   // Soft-start reference; any lockout forces a full ramp on the next start
   always_ff @(posedge ref_clk_in) begin
      if (reset_in || !active) begin
         ss_ref <= pwm_startup_pkg::SS_ZERO;
      end else if (timing.cycle_start && !ss_done) begin
         ss_ref <= ss_ref + pwm_startup_pkg::SS_STEP;
      end
   end

   // Gate drive; comparator turn-off terms are checked before turn-on so a trip always wins
   always_ff @(posedge ref_clk_in) begin
      if (reset_in || !active) begin
         gate <= 1'b0;
      end else if (current_limit_comparator_in || pwm_comparator_in) begin
         gate <= 1'b0;
      end else if (timing.cycle_start) begin
         gate <= 1'b1;
      end else if (!timing.on_window) begin
         gate <= 1'b0;
      end
   end

   // Open-drain flag pulled low only from the enable comparison
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         flag_oe <= 1'b0;
      end else begin
         flag_oe <= !enable_threshold_input_in;
      end
   end

   assign timing.osc_enable        = active;
   assign gate_drive_out           = gate;
   assign undervoltage_flag_out    = 1'b0;
   assign undervoltage_flag_oe_out = flag_oe;
   assign comparators_enable_out   = active;
   assign oscillator_enable_out    = active;
   assign lockout_out              = !active;
   assign softstart_ref_out        = ss_ref;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);

   a_lockout_gate_off: assert property (
      state == pwm_startup_pkg::ST_LOCKOUT |=> !gate_drive_out)
      else $error("gate switched during lockout");

   a_start_needs_all: assert property (
      state == pwm_startup_pkg::ST_LOCKOUT && next_state == pwm_startup_pkg::ST_SOFTSTART
      |-> supply_above_min_in && enable_threshold_input_in && (!BOOTSTRAP || boot_ok))
      else $error("left lockout without all conditions");

   a_boot_low_lockout: assert property (
      BOOTSTRAP && active && !supply_above_boot_low_in |=> ##1 state == pwm_startup_pkg::ST_LOCKOUT)
      else $error("supply collapse did not lock out");

   a_flag_follows_en: assert property (
      enable_threshold_input_in |=> !undervoltage_flag_oe_out ##0 !undervoltage_flag_out)
      else $error("flag not released with enable high");

   a_flag_low_en: assert property (
      !enable_threshold_input_in |=> undervoltage_flag_oe_out)
      else $error("flag not driven with enable low");

   a_delay_holds: assert property (
      state == pwm_startup_pkg::ST_SHUTDOWN && supply_ok && !enable_threshold_input_in && !delay_done
      |=> state == pwm_startup_pkg::ST_SHUTDOWN)
      else $error("shutdown before delay ran out");

   a_delay_ends: assert property (
      state == pwm_startup_pkg::ST_SHUTDOWN && !enable_threshold_input_in && delay_done
      |=> state == pwm_startup_pkg::ST_LOCKOUT ##1 !gate_drive_out)
      else $error("switching continued after delay");

   a_ss_clear: assert property (
      state == pwm_startup_pkg::ST_LOCKOUT |=> softstart_ref_out == pwm_startup_pkg::SS_ZERO)
      else $error("soft-start not cleared in lockout");

   a_ss_step: assert property (
      active && next_state != pwm_startup_pkg::ST_LOCKOUT && timing.cycle_start && !ss_done
      |=> softstart_ref_out == $past(softstart_ref_out) + pwm_startup_pkg::SS_STEP)
      else $error("soft-start did not step");

   a_ss_hold: assert property (
      !timing.cycle_start && active && next_state != pwm_startup_pkg::ST_LOCKOUT
      |=> $stable(softstart_ref_out))
      else $error("soft-start moved off a cycle boundary");

   a_current_limit_comparator_ends_on: assert property (
      current_limit_comparator_in ##1 current_limit_comparator_in [*1] |-> ##[0:CURRENT_LIMIT_COMPARATOR_BOUND] !gate_drive_out)
      else $error("current limit did not end on-time");

   a_pwm_turn_on: assert property (
      active && next_state == state && timing.cycle_start && !pwm_comparator_in && !current_limit_comparator_in
      |=> gate_drive_out)
      else $error("gate not turned on at period start");

   a_duty_limit: assert property (
      !timing.on_window && !timing.cycle_start |=> !gate_drive_out)
      else $error("gate on past duty limit");

   // Supply and gate-drive guards; comparator turn-off must beat period start every cycle
   a_supply_min_loss: assert property (
      active && !supply_above_min_in |=> state == pwm_startup_pkg::ST_LOCKOUT)
      else $error("supply minimum loss did not lock out");

   a_boot_holds_off: assert property (
      BOOTSTRAP && state == pwm_startup_pkg::ST_LOCKOUT && !boot_ok |=> state == pwm_startup_pkg::ST_LOCKOUT)
      else $error("left lockout below bootstrap threshold");

   a_current_limit_comparator_blocks_on: assert property (
      current_limit_comparator_in |=> !gate_drive_out)
      else $error("gate on with current limit tripped");

   a_pwm_ends_on: assert property (
      pwm_comparator_in |=> !gate_drive_out)
      else $error("gate on with pwm comparator high");

   a_osc_held_off: assert property (
      !active |=> !timing.cycle_start)
      else $error("switching period started in lockout");

   a_shutdown_switches: assert property (
      state == pwm_startup_pkg::ST_SHUTDOWN && timing.cycle_start &&
      !pwm_comparator_in && !current_limit_comparator_in |=> gate_drive_out)
      else $error("gate stopped during shutdown delay");

   a_delay_restart: assert property (
      state != pwm_startup_pkg::ST_SHUTDOWN |=> delay_count == '0)
      else $error("delay counter not restarted");

   // Soft-start guards; a run state with a partial ramp would let the output overshoot
   a_ss_enter_zero: assert property (
      state == pwm_startup_pkg::ST_LOCKOUT && next_state == pwm_startup_pkg::ST_SOFTSTART
      |=> softstart_ref_out == pwm_startup_pkg::SS_ZERO)
      else $error("soft-start did not begin at zero");

   a_ss_saturate: assert property (
      active && ss_done |=> softstart_ref_out == pwm_startup_pkg::SS_FULL)
      else $error("soft-start left full scale");

   a_ss_bounded: assert property (
      softstart_ref_out <= pwm_startup_pkg::SS_FULL)
      else $error("soft-start beyond full scale");

   a_run_needs_full: assert property (
      state == pwm_startup_pkg::ST_RUN |-> ss_done)
      else $error("run state before ramp complete");

   a_flag_ignores_boot: assert property (
      state == pwm_startup_pkg::ST_LOCKOUT && enable_threshold_input_in |=> !undervoltage_flag_oe_out)
      else $error("flag driven by supply lockout");

   c_reach_run: cover property (state == pwm_startup_pkg::ST_SOFTSTART ##1 state == pwm_startup_pkg::ST_RUN);
   c_delay_expire: cover property (state == pwm_startup_pkg::ST_SHUTDOWN ##1 state == pwm_startup_pkg::ST_LOCKOUT);
   c_delay_recover: cover property (state == pwm_startup_pkg::ST_SHUTDOWN ##1 state == pwm_startup_pkg::ST_RUN);
   c_current_limit_comparator_trip: cover property (gate_drive_out && current_limit_comparator_in ##1 !gate_drive_out);
   c_boot_collapse: cover property (active && !boot_ok ##1 state == pwm_startup_pkg::ST_LOCKOUT);

endmodule : pwm_startup_ctrl

// ### hdl/pwm_startup_pkg.sv
package pwm_startup_pkg;

   // Controller sequencing states
   typedef enum logic [1:0] {
      ST_LOCKOUT   = 2'b00,
      ST_SOFTSTART = 2'b01,
      ST_RUN       = 2'b10,
      ST_SHUTDOWN  = 2'b11
   } ctrl_state_t;

   // Reference clock
   localparam int CLK_PERIOD_NS = 4;

   // Delay from enable loss to end of switching
   localparam int SHUTDOWN_DELAY_NS     = 210000;
   localparam int SHUTDOWN_DELAY_CYCLES = SHUTDOWN_DELAY_NS / CLK_PERIOD_NS;
   localparam int SHUTDOWN_CNT_W        = 16;

   // Current-limit propagation budget
   localparam int CURRENT_LIMIT_COMPARATOR_PROP_NS     = 60;
   localparam int CURRENT_LIMIT_COMPARATOR_PROP_CYCLES = CURRENT_LIMIT_COMPARATOR_PROP_NS / CLK_PERIOD_NS;

   // Soft-start ramp: one step per switching cycle up to full scale
   localparam int                SS_W         = 11;
   localparam logic [SS_W-1:0]   SS_FULL      = 11'h7C0;
   localparam logic [SS_W-1:0]   SS_ZERO      = 11'h000;
   localparam logic [SS_W-1:0]   SS_STEP      = 11'h001;

   // Oscillator division and on-phase limits per rate variant
   localparam int               PHASE_W       = 2;
   localparam logic [PHASE_W-1:0] HALF_LAST   = 2'h1;
   localparam logic [PHASE_W-1:0] HALF_ON     = 2'h1;
   localparam logic [PHASE_W-1:0] QUARTER_LAST = 2'h3;
   localparam logic [PHASE_W-1:0] QUARTER_ON  = 2'h3;
   localparam logic [PHASE_W-1:0] PHASE_ZERO  = 2'h0;
   localparam logic [PHASE_W-1:0] PHASE_STEP  = 2'h1;

endpackage : pwm_startup_pkg

// ### hdl/switch_timing_if.sv
`timescale 1ns/1ns
// Switching-period timing passed from the divider to the controller
interface switch_timing_if;
   logic osc_enable;
   logic cycle_start;
   logic on_window;

   modport gen  (input osc_enable, output cycle_start, output on_window);
   modport ctrl (output osc_enable, input cycle_start, input on_window);
endinterface : switch_timing_if

// ### hdl/switch_period_gen.sv
`timescale 1ns/1ns
// Divides oscillator ticks to the switching rate and marks the allowed on-phase
module switch_period_gen #(
   parameter bit QUARTER_RATE = 1'b0
) (
   input  wire logic        ref_clk_in,
   input  wire logic        reset_in,
   input  wire logic        osc_tick_in,
   switch_timing_if.gen     timing
);

   localparam logic [pwm_startup_pkg::PHASE_W-1:0] LAST =
      QUARTER_RATE ? pwm_startup_pkg::QUARTER_LAST : pwm_startup_pkg::HALF_LAST;
   localparam logic [pwm_startup_pkg::PHASE_W-1:0] ON_PHASES =
      QUARTER_RATE ? pwm_startup_pkg::QUARTER_ON : pwm_startup_pkg::HALF_ON;

   logic [pwm_startup_pkg::PHASE_W-1:0] phase;
   logic                                cycle_start;

   // Oscillator phase; held at zero while the oscillator is shut down
   always_ff @(posedge ref_clk_in) begin
      if (reset_in || !timing.osc_enable) begin
         phase <= pwm_startup_pkg::PHASE_ZERO;
      end else if (osc_tick_in) begin
         phase <= (phase == LAST) ? pwm_startup_pkg::PHASE_ZERO : phase + pwm_startup_pkg::PHASE_STEP;
      end
   end

   // One-cycle mark when a new switching period begins
   always_ff @(posedge ref_clk_in) begin
      if (reset_in || !timing.osc_enable) begin
         cycle_start <= 1'b0;
      end else begin
         cycle_start <= osc_tick_in && (phase == LAST);
      end
   end

   // Later phases are off-time, which caps the duty cycle
   assign timing.on_window   = timing.osc_enable && (phase < ON_PHASES);
   assign timing.cycle_start = cycle_start;

   a_period_phase: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      cycle_start |-> phase == pwm_startup_pkg::PHASE_ZERO && timing.on_window)
      else $error("period start not at phase zero");

endmodule : switch_period_gen

// ### verif/mosfet_sense_model.sv
`timescale 1ns/1ns
// Far side: power switch with its sense resistor, plus the pull-up on the flag line
module mosfet_sense_model (
   input  wire logic       ref_clk_in,
   input  wire logic       gate_in,
   input  wire logic [7:0] on_limit_in,
   input  wire logic       overcurrent_in,
   input  wire logic       flag_oe_in,
   output logic            pwm_comparator_out,
   output logic            current_limit_comparator_out,
   output logic            flag_level_out
);
   logic [7:0] on_time = 8'h00;
   // Switch current is modelled as the number of cycles spent on
   always_ff @(posedge ref_clk_in) begin
      on_time <= gate_in ? on_time + 8'h01 : 8'h00;
   end
   // Sense is zero while off, so the comparator can only trip during an on-phase
   assign pwm_comparator_out           = gate_in && (on_time >= on_limit_in);
   assign current_limit_comparator_out = overcurrent_in;
   // Open drain with pull-up: the line never floats to the last driven value
   assign flag_level_out               = flag_oe_in ? 1'b0 : 1'b1;
endmodule : mosfet_sense_model

// ### verif/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic        ref_clk_in = 1'b0;
   logic        reset_in   = 1'b1;
   logic        tick       = 1'b0;
   logic        sup_min    = 1'b1;
   logic        boot_hi    = 1'b0;
   logic        boot_lo    = 1'b0;
   logic        en         = 1'b1;
   logic        ovc        = 1'b0;
   logic [7:0]  lim        = 8'hFF;
   logic [2:0]  tcnt       = 3'h0;
   logic        pwm_cmp, current_limit_comparator_cmp, flag_lvl;
   logic [1:0]  gate, oe, fl, cen, oen, lk;
   logic [10:0] ss0, ss1;
   int          err_count  = 0;
   int          n_compared = 0;
   int          cyc        = 0;
   int          h0, h1;
   always #2 ref_clk_in = ~ref_clk_in;
   // One oscillator tick every eight clocks gives an on-window long enough to probe
   always @(posedge ref_clk_in) begin
      tcnt <= tcnt + 3'h1;
      tick <= (tcnt == 3'h7);
      cyc  <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         results();
      end
   end
   pwm_startup_ctrl #(.BOOTSTRAP(1'b1), .SHUTDOWN_DELAY_CYCLES(16'h0014)) pwm_startup_ctrl_i (
      .ref_clk_in(ref_clk_in), .reset_in(reset_in), .osc_tick_in(tick), .supply_above_min_in(sup_min),
      .supply_above_boot_high_in(boot_hi), .supply_above_boot_low_in(boot_lo), .enable_threshold_input_in(en),
      .pwm_comparator_in(pwm_cmp), .current_limit_comparator_in(current_limit_comparator_cmp), .gate_drive_out(gate[0]),
      .undervoltage_flag_out(fl[0]), .undervoltage_flag_oe_out(oe[0]), .comparators_enable_out(cen[0]),
      .oscillator_enable_out(oen[0]), .lockout_out(lk[0]), .softstart_ref_out(ss0));
   // Second variant shares the stimulus; its comparators see the first switch's sense
   pwm_startup_ctrl #(.BOOTSTRAP(1'b0), .QUARTER_RATE(1'b1), .SHUTDOWN_DELAY_CYCLES(16'h0014)) pwm_startup_ctrl_i_alt (
      .ref_clk_in(ref_clk_in), .reset_in(reset_in), .osc_tick_in(tick), .supply_above_min_in(sup_min),
      .supply_above_boot_high_in(boot_hi), .supply_above_boot_low_in(boot_lo), .enable_threshold_input_in(en),
      .pwm_comparator_in(pwm_cmp), .current_limit_comparator_in(current_limit_comparator_cmp), .gate_drive_out(gate[1]),
      .undervoltage_flag_out(fl[1]), .undervoltage_flag_oe_out(oe[1]), .comparators_enable_out(cen[1]),
      .oscillator_enable_out(oen[1]), .lockout_out(lk[1]), .softstart_ref_out(ss1));
   mosfet_sense_model mosfet_sense_model_i (
      .ref_clk_in(ref_clk_in), .gate_in(gate[0]), .on_limit_in(lim), .overcurrent_in(ovc), .flag_oe_in(oe[0]),
      .pwm_comparator_out(pwm_cmp), .current_limit_comparator_out(current_limit_comparator_cmp), .flag_level_out(flag_lvl));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   // Outputs are sampled on the falling edge, well clear of the updates
   task automatic step(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask : step
   task automatic count_hi(input int n);
      h0 = 0;
      h1 = 0;
      repeat (n) begin
         @(negedge ref_clk_in);
         h0 += (gate[0] === 1'b1);
         h1 += (gate[1] === 1'b1);
      end
   endtask : count_hi
   task automatic t_lockout();
      step(30);
      chk("boot_lockout", 1, lk[0]);
      chk("gate_off", 0, gate[0]);
      chk("comp_en_off", 0, cen[0]);
      chk("osc_en_off", 0, oen[0]);
      chk("flag_released", 1, flag_lvl);
      chk("flag_data_low", 0, fl[0]);
      chk("alt_started", 0, lk[1]);
      @(posedge ref_clk_in) en <= 1'b0;
      step(3);
      chk("flag_low", 0, flag_lvl);
      chk("alt_flag_low", 1, oe[1]);
      step(30);
      chk("alt_needs_enable", 1, lk[1]);
      @(posedge ref_clk_in) en <= 1'b1;
      step(3);
      chk("flag_high", 1, flag_lvl);
      chk("alt_flag_high", 0, oe[1]);
   endtask : t_lockout
   task automatic t_start();
      @(posedge ref_clk_in) begin
         boot_hi <= 1'b1;
         boot_lo <= 1'b1;
      end
      step(4);
      chk("started", 0, lk[0]);
      chk("comp_en_on", 1, cen[0]);
      chk("ss_from_zero", 1, ss0 <= 11'h001);
      @(posedge ref_clk_in) boot_hi <= 1'b0;
      step(160);
      chk("ss_ten_cycles", 1, ss0 >= 11'h009 && ss0 <= 11'h00B);
   endtask : t_start
   task automatic t_duty();
      count_hi(160);
      chk("half_duty", 1, h0 <= 80 && h0 >= 60);
      chk("quarter_duty", 1, h1 <= 120 && h1 >= 100);
      @(posedge ref_clk_in) lim <= 8'h02;
      count_hi(160);
      chk("pwm_turnoff", 1, h0 <= 40 && h0 > 0);
      @(posedge ref_clk_in) lim <= 8'hFF;
   endtask : t_duty
   task automatic t_current_limit_comparator();
      int k;
      // Leave the launching edge before looking at the gate
      step(1);
      for (k = 0; k < 100 && gate[0] !== 1'b1; k++) step(1);
      chk("gate_rise", 1, gate[0]);
      @(posedge ref_clk_in) ovc <= 1'b1;
      step(pwm_startup_pkg::CURRENT_LIMIT_COMPARATOR_PROP_CYCLES);
      chk("current_limit_comparator_off", 0, gate[0]);
      count_hi(64);
      chk("current_limit_comparator_held_off", 0, h0);
      @(posedge ref_clk_in) ovc <= 1'b0;
   endtask : t_current_limit_comparator
   task automatic t_ss_full();
      int k;
      step(1);
      for (k = 0; k < 40000 && ss0 !== pwm_startup_pkg::SS_FULL; k++) step(1);
      step(100);
      chk("ss_saturated", pwm_startup_pkg::SS_FULL, ss0);
   endtask : t_ss_full
   task automatic t_shutdown();
      @(posedge ref_clk_in) en <= 1'b0;
      step(10);
      @(posedge ref_clk_in) en <= 1'b1;
      step(30);
      chk("recovered", 0, lk[0]);
      @(posedge ref_clk_in) en <= 1'b0;
      count_hi(15);
      chk("still_active", 0, lk[0]);
      chk("still_switching", 1, h0 > 0);
      step(10);
      chk("shut_down", 1, lk[0]);
      chk("gate_stopped", 0, gate[0]);
      chk("ss_cleared", 0, ss0);
      @(posedge ref_clk_in) en <= 1'b1;
      step(4);
   endtask : t_shutdown
   task automatic t_boot_loss();
      @(posedge ref_clk_in) boot_lo <= 1'b0;
      step(4);
      chk("boot_collapse", 1, lk[0]);
      chk("osc_off", 0, oen[0]);
      chk("flag_unaffected", 1, flag_lvl);
      @(posedge ref_clk_in) boot_lo <= 1'b1;
      step(10);
      chk("no_restart_low", 1, lk[0]);
      @(posedge ref_clk_in) boot_hi <= 1'b1;
      step(4);
      chk("restarted", 0, lk[0]);
      step(160);
      chk("ss_rerun", 1, ss0 >= 11'h009 && ss0 <= 11'h00B);
   endtask : t_boot_loss
   // Supply minimum loss locks out both variants; the flag must not follow it
   task automatic t_supply_min();
      @(posedge ref_clk_in) sup_min <= 1'b0;
      step(4);
      chk("min_lockout", 1, lk[0]);
      chk("alt_min_lockout", 1, lk[1]);
      chk("min_gate_off", 0, gate[1]);
      chk("min_ss_cleared", 0, ss1);
      chk("min_flag_released", 1, flag_lvl);
      chk("alt_flag_data", 0, fl[1]);
      @(posedge ref_clk_in) sup_min <= 1'b1;
      step(4);
      chk("alt_restarted", 0, lk[1]);
      step(160);
      chk("alt_ss_quarter", 1, ss1 >= 11'h004 && ss1 <= 11'h006);
   endtask : t_supply_min
   task automatic results();
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   initial begin
      repeat (10) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      t_lockout();
      t_start();
      t_duty();
      t_current_limit_comparator();
      t_ss_full();
      t_shutdown();
      t_boot_loss();
      t_supply_min();
      results();
   end
endmodule : testbench
